// file: common/e3rx_pkg.sv
// Shared constants and carrier types for the E3 receive status latch bank
package e3rx_pkg;

	// ****************************************
	// Register indices (byte address is four times the index)
	// ****************************************
	localparam logic [7:0] E3RX_IDX_LIVE_A = 8'h24;
	localparam logic [7:0] E3RX_IDX_LIVE_B = 8'h26;
	localparam logic [7:0] E3RX_IDX_LAT_A = 8'h28;
	localparam logic [7:0] E3RX_IDX_LAT_B = 8'h2a;

	// ****************************************
	// Implemented bit masks and reset values
	// ****************************************
	localparam logic [15:0] E3RX_LIVE_A_MASK = 16'h191f;
	localparam logic [15:0] E3RX_LIVE_B_MASK = 16'h0007;
	localparam logic [15:0] E3RX_LAT_A_MASK = 16'h3dff;
	localparam logic [15:0] E3RX_LAT_B_MASK = 16'h0707;
	localparam logic [15:0] E3RX_LAT_RESET = 16'h0000;
	localparam logic [31:0] E3RX_RDATA_RESET = 32'h0000_0000;

	// ****************************************
	// Field positions, live status words
	// ****************************************
	localparam int E3RX_B_PT_UNSTABLE = 12;
	localparam int E3RX_B_PT_MISMATCH = 11;
	localparam int E3RX_B_ALL_ONES = 8;
	localparam int E3RX_B_LOF = 4;
	localparam int E3RX_B_RDI = 3;
	localparam int E3RX_B_AIS = 2;
	localparam int E3RX_B_OOF = 1;
	localparam int E3RX_B_LOS = 0;
	localparam int E3RX_B_REI_CNT = 2;
	localparam int E3RX_B_PAR_CNT = 1;
	localparam int E3RX_B_FRM_CNT = 0;

	// ****************************************
	// Field positions, latched words
	// ****************************************
	localparam int E3RX_L_TIMING = 13;
	localparam int E3RX_L_PT_CHANGE = 10;
	localparam int E3RX_L_COMM = 7;
	localparam int E3RX_L_OPER = 6;
	localparam int E3RX_L_ALIGN = 5;
	localparam int E3RX_L_REI = 10;
	localparam int E3RX_L_PAR = 9;
	localparam int E3RX_L_FRM = 8;

	// ****************************************
	// Carrier types
	// ****************************************
	typedef struct packed {
		logic payload_type_unstable;
		logic payload_type_mismatch;
		logic unframed_all_ones;
		logic lof;
		logic rdi;
		logic ais;
		logic oof;
	} e3rx_flags_t;

	typedef struct packed {
		logic [3:0] timing_source_bits;
		logic [2:0] received_payload_type;
		logic [7:0] received_comm_byte;
		logic [7:0] received_operator_byte;
	} e3rx_ovh_t;

	typedef struct packed {
		logic remote;
		logic parity;
		logic framing;
	} e3rx_err_t;

endpackage

// file: logic/e3rx_status.sv
// E3 receive live status and latched event registers behind an Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none

module e3rx_status
	import e3rx_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire e3rx_flags_t rx_flags,
	input wire e3rx_ovh_t rx_ovh,
	input wire e3rx_err_t counter_nonzero,
	input wire e3rx_err_t error_pulse,
	input wire logic alignment_changed,
	input wire logic loss_of_signal_input_pin,
	input wire logic [15:0] int_enable_a,
	input wire logic [15:0] int_enable_b,
	input wire logic port_int_enable,
	output logic status_irq
);

	// ****************************************
	// Pin synchroniser
	// ****************************************
	logic los_meta;
	logic los_sync;

	// Loss-of-signal arrives from a pin, two stages before use
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			los_meta <= 1'b0;
			los_sync <= 1'b0;
		end
		else
		begin
			los_meta <= loss_of_signal_input_pin;
			los_sync <= los_meta;
		end
	end

	// ****************************************
	// Live status words
	// ****************************************
	logic [15:0] live_a;
	logic [15:0] live_b;

	// Live words are plain wiring of the frame processor flags, the synchronised loss of signal and the counter-nonzero inputs
	always_comb
	begin
		live_a = 16'h0000;
		live_a[E3RX_B_PT_UNSTABLE] = rx_flags.payload_type_unstable;
		live_a[E3RX_B_PT_MISMATCH] = rx_flags.payload_type_mismatch;
		live_a[E3RX_B_ALL_ONES] = rx_flags.unframed_all_ones;
		live_a[E3RX_B_LOF] = rx_flags.lof;
		live_a[E3RX_B_RDI] = rx_flags.rdi;
		live_a[E3RX_B_AIS] = rx_flags.ais;
		live_a[E3RX_B_OOF] = rx_flags.oof;
		live_a[E3RX_B_LOS] = los_sync;
		live_b = 16'h0000;
		live_b[E3RX_B_REI_CNT] = counter_nonzero.remote;
		live_b[E3RX_B_PAR_CNT] = counter_nonzero.parity;
		live_b[E3RX_B_FRM_CNT] = counter_nonzero.framing;
	end

	// ****************************************
	// History for change detection
	// ****************************************
	logic primed;
	logic [15:0] prev_a;
	logic [15:0] prev_b;
	e3rx_ovh_t prev_ovh;

	// First cycle after reset only captures history, so no false change fires
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			primed <= 1'b0;
			prev_a <= 16'h0000;
			prev_b <= 16'h0000;
			prev_ovh <= '0;
		end
		else
		begin
			primed <= 1'b1;
			prev_a <= live_a;
			prev_b <= live_b;
			prev_ovh <= rx_ovh;
		end
	end

	// ****************************************
	// Event detection
	// ****************************************
	logic [15:0] evt_a;
	logic [15:0] evt_b;
	logic [15:0] chg_a;
	logic [15:0] rise_a;
	logic [15:0] rise_b;

	// Edge terms against last cycle's snapshot
	assign chg_a = live_a ^ prev_a;
	assign rise_a = live_a & ~prev_a;
	assign rise_b = live_b & ~prev_b;

	// Any-edge, rising-edge and direct pulse events, all gated until history is valid
	always_comb
	begin
		evt_a = 16'h0000;
		evt_b = 16'h0000;
		if (primed)
		begin
			evt_a[E3RX_L_TIMING] = rx_ovh.timing_source_bits != prev_ovh.timing_source_bits;
			evt_a[E3RX_B_PT_UNSTABLE] = rise_a[E3RX_B_PT_UNSTABLE];
			evt_a[E3RX_B_PT_MISMATCH] = rise_a[E3RX_B_PT_MISMATCH];
			evt_a[E3RX_L_PT_CHANGE] = rx_ovh.received_payload_type !=
				prev_ovh.received_payload_type;
			evt_a[E3RX_B_ALL_ONES] = chg_a[E3RX_B_ALL_ONES];
			evt_a[E3RX_L_COMM] = rx_ovh.received_comm_byte != prev_ovh.received_comm_byte;
			evt_a[E3RX_L_OPER] = rx_ovh.received_operator_byte !=
				prev_ovh.received_operator_byte;
			evt_a[E3RX_L_ALIGN] = alignment_changed;
			evt_a[E3RX_B_LOF:E3RX_B_LOS] = chg_a[E3RX_B_LOF:E3RX_B_LOS];
			evt_b[E3RX_L_REI] = error_pulse.remote;
			evt_b[E3RX_L_PAR] = error_pulse.parity;
			evt_b[E3RX_L_FRM] = error_pulse.framing;
			evt_b[E3RX_B_REI_CNT:E3RX_B_FRM_CNT] = rise_b[E3RX_B_REI_CNT:E3RX_B_FRM_CNT];
		end
	end

	// ****************************************
	// Avalon-MM slave
	// ****************************************
	logic hit_live_a;
	logic hit_live_b;
	logic hit_lat_a;
	logic hit_lat_b;
	logic wr_take;
	logic [15:0] clr_lanes;
	logic [15:0] clr_a;
	logic [15:0] clr_b;
	logic [15:0] lat_a;
	logic [15:0] lat_b;

	// Address decode against the byte address of each word
	assign hit_live_a = avs_address == {E3RX_IDX_LIVE_A, 2'b00};
	assign hit_live_b = avs_address == {E3RX_IDX_LIVE_B, 2'b00};
	assign hit_lat_a = avs_address == {E3RX_IDX_LAT_A, 2'b00};
	assign hit_lat_b = avs_address == {E3RX_IDX_LAT_B, 2'b00};
	// A write lands only on the edge where waitrequest is seen low
	assign wr_take = avs_write && !avs_waitrequest;
	assign clr_lanes = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign clr_a = (wr_take && hit_lat_a) ? (avs_writedata[15:0] & clr_lanes) : 16'h0000;
	assign clr_b = (wr_take && hit_lat_b) ? (avs_writedata[15:0] & clr_lanes) : 16'h0000;

	// One wait cycle per access; released for exactly one cycle, then raised again
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			avs_waitrequest <= 1'b1;
		else if ((avs_read || avs_write) && avs_waitrequest)
			avs_waitrequest <= 1'b0;
		else
			avs_waitrequest <= 1'b1;
	end

	// Read data captured in the wait cycle; unmapped addresses read zero
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			avs_readdata <= E3RX_RDATA_RESET;
		else if (avs_read && avs_waitrequest)
		begin
			if (hit_live_a)
				avs_readdata <= {16'h0000, live_a & E3RX_LIVE_A_MASK};
			else if (hit_live_b)
				avs_readdata <= {16'h0000, live_b & E3RX_LIVE_B_MASK};
			else if (hit_lat_a)
				avs_readdata <= {16'h0000, lat_a};
			else if (hit_lat_b)
				avs_readdata <= {16'h0000, lat_b};
			else
				avs_readdata <= E3RX_RDATA_RESET;
		end
	end

	// ****************************************
	// Latched event registers
	// ****************************************
	// Set term is or-ed after the clear so a coincident event survives
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			lat_a <= E3RX_LAT_RESET;
			lat_b <= E3RX_LAT_RESET;
		end
		else
		begin
			lat_a <= ((lat_a & ~clr_a) | evt_a) & E3RX_LAT_A_MASK;
			lat_b <= ((lat_b & ~clr_b) | evt_b) & E3RX_LAT_B_MASK;
		end
	end

	// ****************************************
	// Interrupt request
	// ****************************************
	// Registered so the output comes from a flop; one cycle behind the latch
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			status_irq <= 1'b0;
		else
			status_irq <= port_int_enable &&
				(|(lat_a & int_enable_a) || |(lat_b & int_enable_b));
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	sequence seq_request;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence

	sequence seq_answer;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence

	a_bus_answer_one: assert property (seq_request |=> seq_answer)
		else $error("waitrequest did not drop for exactly one cycle");

	a_los_two_stage: assert property (
		##2 (los_sync == $past(loss_of_signal_input_pin, 2)))
		else $error("loss of signal not delayed by two flops");

	a_live_read_a: assert property (
		avs_read && !avs_waitrequest && hit_live_a |->
		avs_readdata == {16'h0000, $past(live_a) & E3RX_LIVE_A_MASK})
		else $error("live status a read mismatch");

	a_unstable_rise: assert property (
		primed && $rose(rx_flags.payload_type_unstable) |=> lat_a[E3RX_B_PT_UNSTABLE])
		else $error("unstable rise not latched");

	a_unstable_fall: assert property (
		!lat_a[E3RX_B_PT_UNSTABLE] && !rx_flags.payload_type_unstable |=>
		!lat_a[E3RX_B_PT_UNSTABLE])
		else $error("unstable latch set without a rise");

	a_mismatch_rise: assert property (
		primed && $rose(rx_flags.payload_type_mismatch) |=> lat_a[E3RX_B_PT_MISMATCH])
		else $error("mismatch rise not latched");

	a_lof_any_edge: assert property (
		primed && $changed(rx_flags.lof) |=> lat_a[E3RX_B_LOF])
		else $error("loss of frame change not latched");

	a_count_rise: assert property (
		primed && $rose(counter_nonzero.parity) |=> lat_b[E3RX_B_PAR_CNT])
		else $error("parity counter rise not latched");

	a_clear_hold: assert property (
		lat_a[E3RX_B_LOF] && !clr_a[E3RX_B_LOF] |=> lat_a[E3RX_B_LOF] [*1])
		else $error("latched bit dropped without a clear");

	a_clear_then_gone: assert property (
		clr_b[E3RX_L_FRM] && !evt_b[E3RX_L_FRM] |=> !lat_b[E3RX_L_FRM])
		else $error("write one did not clear latched bit");

	a_set_wins: assert property (
		(|(clr_a & evt_a)) || (|(clr_b & evt_b)) |=>
		((lat_a & $past(clr_a & evt_a)) == $past(clr_a & evt_a)) &&
		((lat_b & $past(clr_b & evt_b)) == $past(clr_b & evt_b)))
		else $error("event lost against a clear");

	a_reserved_zero: assert property (
		((lat_a & ~E3RX_LAT_A_MASK) == 16'h0000) && ((lat_b & ~E3RX_LAT_B_MASK) == 16'h0000))
		else $error("reserved latch bit set");

	a_irq_gating: assert property (
		##1 (status_irq == $past(port_int_enable &&
		(|(lat_a & int_enable_a) || |(lat_b & int_enable_b)))))
		else $error("interrupt not gated by enables");

	a_live_read_b: assert property (
		avs_read && !avs_waitrequest && hit_live_b |->
		avs_readdata == {16'h0000, $past(live_b) & E3RX_LIVE_B_MASK})
		else $error("live status b read mismatch");

	a_latch_read: assert property (
		avs_read && !avs_waitrequest && hit_lat_a |->
		avs_readdata == {16'h0000, $past(lat_a)})
		else $error("latched word a read mismatch");

	a_pt_change: assert property (
		primed && $changed(rx_ovh.received_payload_type) |=> lat_a[E3RX_L_PT_CHANGE])
		else $error("payload type change not latched");

	a_frame_error: assert property (
		primed && error_pulse.framing |=> lat_b[E3RX_L_FRM])
		else $error("framing error not latched");

	a_los_change: assert property (
		primed && $changed(los_sync) |=> lat_a[E3RX_B_LOS])
		else $error("loss of signal change not latched");

endmodule

`default_nettype wire

// file: verification/e3rx_status_tb.sv
// Self-checking bench for the E3 receive status and latched event registers
`timescale 1ns/1ps
`default_nettype none

module e3rx_status_tb
	import e3rx_pkg::*;
;
	// ****************************************
	// Stimulus and observation signals
	// ****************************************
	logic sys_clk, rst_b, avs_read, avs_write, avs_waitrequest, status_irq;
	logic los_pin, port_en, align;
	logic [9:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0] avs_byteenable;
	logic [15:0] ien_a, ien_b;
	e3rx_flags_t flags;
	e3rx_ovh_t ovh;
	e3rx_err_t cnz, epulse;
	int bad_count, checks_done;
	logic [15:0] exp_ovh [5] = '{16'h2000, 16'h0400, 16'h0080, 16'h0040, 16'h0020};
	localparam logic [9:0] A_LA = {E3RX_IDX_LIVE_A, 2'b00};
	localparam logic [9:0] A_LB = {E3RX_IDX_LIVE_B, 2'b00};
	localparam logic [9:0] A_TA = {E3RX_IDX_LAT_A, 2'b00};
	localparam logic [9:0] A_TB = {E3RX_IDX_LAT_B, 2'b00};

	e3rx_status u_dut (
		.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .rx_flags(flags), .rx_ovh(ovh),
		.counter_nonzero(cnz), .error_pulse(epulse), .alignment_changed(align),
		.loss_of_signal_input_pin(los_pin), .int_enable_a(ien_a),
		.int_enable_b(ien_b), .port_int_enable(port_en), .status_irq(status_irq)
	);

	// 10 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic close_out();
		$display("mismatches %0d of %0d checks", bad_count, checks_done);
		if (bad_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// One bus access; tog flips the frame-loss flag so it lands on the clearing edge
	task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d,
		input logic [3:0] be, input logic tog);
		int n;
		n = 0;
		avs_address <= a;
		avs_read <= ~wr;
		avs_write <= wr;
		avs_writedata <= d;
		avs_byteenable <= be;
		do
		begin
			@(posedge sys_clk);
			n++;
			if (tog && n == 1)
				flags.lof <= ~flags.lof;
		end
		while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20)
		begin
			bad_count++;
			close_out();
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// Idle edge keeps a following request from re-driving in this time step
		@(posedge sys_clk);
	endtask

	task automatic rchk(input logic [9:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0, 4'hf, 1'b0);
		chk(rd, exp);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		{rst_b, avs_read, avs_write, los_pin, port_en, align} <= '0;
		{avs_address, avs_writedata, avs_byteenable, ien_a, ien_b} <= '0;
		{flags, ovh, cnz, epulse} <= '0;
		cyc(4);
		rst_b <= 1'b1;
		// Let change history arm before any input moves
		cyc(3);
		rchk(A_TA, 32'h0);
		rchk(A_TB, 32'h0);
		rchk(10'h094, 32'h0);
		// All flags rise together
		flags <= '1;
		los_pin <= 1'b1;
		cnz <= '1;
		cyc(5);
		rchk(A_LA, 32'h191f);
		rchk(A_LB, 32'h0007);
		rchk(A_TA, 32'h191f);
		rchk(A_TB, 32'h0007);
		// Byte lanes clear independently
		xfer(1'b1, A_TA, 32'hffff, 4'h2, 1'b0);
		rchk(A_TA, 32'h001f);
		xfer(1'b1, A_TA, 32'hffff, 4'h1, 1'b0);
		rchk(A_TA, 32'h0);
		xfer(1'b1, A_TB, 32'hffff, 4'hf, 1'b0);
		// Falling edges: only the any-change latches set
		flags <= '0;
		los_pin <= 1'b0;
		cnz <= '0;
		cyc(5);
		rchk(A_LA, 32'h0);
		rchk(A_TA, 32'h011f);
		rchk(A_TB, 32'h0);
		xfer(1'b1, A_TA, 32'hffff, 4'hf, 1'b0);
		// Overhead fields and alignment, one at a time
		for (int i = 0; i < 5; i++)
		begin
			case (i)
				0: ovh.timing_source_bits <= 4'h8;
				1: ovh.received_payload_type <= 3'h5;
				2: ovh.received_comm_byte <= 8'h80;
				3: ovh.received_operator_byte <= 8'h01;
				default: align <= 1'b1;
			endcase
			cyc(1);
			align <= 1'b0;
			cyc(3);
			rchk(A_TA, {16'h0, exp_ovh[i]});
			xfer(1'b1, A_TA, 32'hffff, 4'hf, 1'b0);
		end
		// Error pulses and counter-nonzero rises, one lane at a time
		for (int i = 0; i < 3; i++)
		begin
			epulse <= 3'b001 << i;
			cnz <= 3'b001 << i;
			cyc(1);
			epulse <= '0;
			cyc(3);
			rchk(A_TB, 32'h0101 << i);
			xfer(1'b1, A_TB, 32'hffff, 4'hf, 1'b0);
		end
		// Interrupt needs both the bit enable and the port enable
		flags.lof <= 1'b1;
		ien_a <= 16'h0010;
		cyc(4);
		chk(status_irq, 1'b0);
		port_en <= 1'b1;
		cyc(3);
		chk(status_irq, 1'b1);
		ien_a <= 16'h0008;
		cyc(3);
		chk(status_irq, 1'b0);
		ien_a <= 16'h0010;
		cyc(1);
		xfer(1'b1, A_TA, 32'hffff, 4'hf, 1'b0);
		cyc(2);
		chk(status_irq, 1'b0);
		// Second latched word reaches the interrupt through its own enables
		ien_b <= 16'h0400;
		epulse <= 3'b100;
		cyc(1);
		epulse <= '0;
		cyc(3);
		chk(status_irq, 1'b1);
		xfer(1'b1, A_TB, 32'hffff, 4'hf, 1'b0);
		cyc(2);
		chk(status_irq, 1'b0);
		// A set in the clearing cycle survives the clear
		xfer(1'b1, A_TA, 32'hffff, 4'hf, 1'b1);
		rchk(A_TA, 32'h0010);
		close_out();
	end
endmodule

`default_nettype wire
